// ==== dtec_top.sv ====
// Purpose: two 16-bit timer/event counters behind a byte register port
// Assumes: one clock; pins are asynchronous and synchronised here
// Notes:   irq enables and flag clears come from the interrupt controller
// Operation
// - counter 0 clocks from system clock or pin
// - counter 1 clocks from clock/4 or pin
// - low byte write fills holding buffer only
// - high byte write loads whole preload
// - high read latches low into buffer
// - mode field selects event, timer, pulse width
// - pulse width counts internal clock while active
// - event and timer count up to FFFF
// - overflow reloads preload and sets flag
// - pulse width overflow behaves the same way
// - pulse width starts on the edge opposite the selected one
// - pulse width end clears run, holds result
// - run bit enables; software clears otherwise
// - edge bit selects counting pin edge
// - stopped counter also loads on preload write
// - counter clock blocked during value read
// - counter 0 bits 2:0 pick prescale stage
// - unused control bits read as zero
// - overflow wakes device; enable gates interrupt
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.svh"

module dtec_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [7:0]       rdata,
    input  wire logic        ctr0_input_pin,
    input  wire logic        ctr1_input_pin,
    input  wire logic        ctr0_irq_enable,
    input  wire logic        ctr1_irq_enable,
    input  wire logic        ctr0_flag_clr,
    input  wire logic        ctr1_flag_clr,
    output logic             ctr0_overflow_flag,
    output logic             ctr1_overflow_flag,
    output logic             ctr0_irq,
    output logic             ctr1_irq,
    output logic             wake_up
);

    function automatic logic dtec_hit(input logic [7:0] a, input logic [7:0] off);
        dtec_hit = (a == off);
    endfunction : dtec_hit

    logic [7:0]                  rdata_ff;
    logic [1:0]                  flag_ff;
    logic [1:0]                  irq_ff;
    logic                        wake_ff;
    logic [`DTEC_PSC_WIDTH-1:0]  psc_cnt_ff;
    logic [1:0]                  div4_ff;
    logic [`DTEC_PSC_WIDTH-1:0]  psc_mask;
    logic [1:0]                  tick;
    logic [1:0]                  pin_meta_ff;
    logic [1:0]                  pin_sync_ff;
    logic [1:0]                  pin_raw;
    logic [1:0]                  irq_en;
    logic [1:0]                  flag_clr;
    logic [7:0]                  ctrl_ff [2];
    logic [7:0]                  hold_ff [2];
    logic [15:0]                 count   [2];
    logic [15:0]                 preload [2];
    logic [1:0]                  ovf;
    logic [1:0]                  run_clr;
    logic [1:0]                  wr_hi;
    logic [1:0]                  wr_lo;
    logic [1:0]                  wr_ctl;
    logic [1:0]                  rd_hi;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    assign pin_raw  = {ctr1_input_pin, ctr0_input_pin};
    assign irq_en   = {ctr1_irq_enable, ctr0_irq_enable};
    assign flag_clr = {ctr1_flag_clr, ctr0_flag_clr};

    assign rdata              = rdata_ff;
    assign ctr0_overflow_flag = flag_ff[0];
    assign ctr1_overflow_flag = flag_ff[1];
    assign ctr0_irq           = irq_ff[0];
    assign ctr1_irq           = irq_ff[1];
    assign wake_up            = wake_ff;

    // free running prescaler, used only by counter 0
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            psc_cnt_ff <= '0;
        end else if (clk_en) begin
            psc_cnt_ff <= psc_cnt_ff + `DTEC_PSC_WIDTH'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div4_ff <= 2'h0;
        end else if (clk_en) begin
            div4_ff <= div4_ff + 2'h1;
        end
    end

    // stage n ticks once every 2**n clocks
    assign psc_mask = `DTEC_PSC_WIDTH'((8'h01 << ctrl_ff[0][`DTEC_CTRL_PSC_HI:`DTEC_CTRL_PSC_LO]) - 8'h01);
    assign tick[0]  = (psc_cnt_ff & psc_mask) == psc_mask;
    assign tick[1]  = (div4_ff == `DTEC_CTR1_DIV_LAST);

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            localparam logic [7:0] OFF_HI  = (i == 0) ? `DTEC_OFF_C0_HIGH : `DTEC_OFF_C1_HIGH;
            localparam logic [7:0] OFF_LO  = (i == 0) ? `DTEC_OFF_C0_LOW  : `DTEC_OFF_C1_LOW;
            localparam logic [7:0] OFF_CTL = (i == 0) ? `DTEC_OFF_C0_CTRL : `DTEC_OFF_C1_CTRL;

            assign wr_hi[i]  = wr_en & dtec_hit(addr, OFF_HI);
            assign wr_lo[i]  = wr_en & dtec_hit(addr, OFF_LO);
            assign wr_ctl[i] = wr_en & dtec_hit(addr, OFF_CTL);
            assign rd_hi[i]  = rd_en & dtec_hit(addr, OFF_HI);

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    pin_meta_ff[i] <= 1'b0;
                    pin_sync_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    pin_meta_ff[i] <= pin_raw[i];
                    pin_sync_ff[i] <= pin_meta_ff[i];
                end
            end

            // one buffer serves both the write and the read path
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    hold_ff[i] <= 8'h00;
                end else if (clk_en) begin
                    if (wr_lo[i]) begin
                        hold_ff[i] <= wdata;
                    end else if (rd_hi[i]) begin
                        hold_ff[i] <= count[i][7:0];
                    end
                end
            end

            // software write outranks the hardware clear of run
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    ctrl_ff[i] <= `DTEC_CTRL_RESET;
                end else if (clk_en) begin
                    if (wr_ctl[i]) begin
                        ctrl_ff[i] <= (i == 0) ? (wdata & 8'hDF) : (wdata & 8'hD8);
                    end else if (run_clr[i]) begin
                        ctrl_ff[i][`DTEC_CTRL_RUN] <= 1'b0;
                    end
                end
            end

            // event set wins over a clear in the same cycle
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    flag_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    if (ovf[i]) begin
                        flag_ff[i] <= 1'b1;
                    end else if (flag_clr[i]) begin
                        flag_ff[i] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    irq_ff[i] <= 1'b0;
                end else if (clk_en) begin
                    irq_ff[i] <= (flag_ff[i] | ovf[i]) & irq_en[i];
                end
            end

            dtec_channel dtec_channel_i (
                .clk        (clk),
                .rst_b      (rst_b),
                .clk_en     (clk_en),
                .mode       (dtec_pkg::dtec_mode_e'(ctrl_ff[i][`DTEC_CTRL_MODE_HI:`DTEC_CTRL_MODE_LO])),
                .run        (ctrl_ff[i][`DTEC_CTRL_RUN]),
                .edge_sel   (ctrl_ff[i][`DTEC_CTRL_EDGE]),
                .tick       (tick[i]),
                .pin_sync   (pin_sync_ff[i]),
                .load       (wr_hi[i]),
                .load_val   ({wdata, hold_ff[i]}),
                .block      (rd_hi[i]),
                .run_clr    (run_clr[i]),
                .count_ff   (count[i]),
                .preload_ff (preload[i]),
                .ovf_ff     (ovf[i])
            );

            AST_LOW_WRITE_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && wr_lo[i] |=> $stable(preload[i]) && hold_ff[i] == $past(wdata))
                else $error("low byte write touched preload");

            AST_HIGH_WRITE_PRELOAD: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && wr_hi[i] |=> preload[i] == {$past(wdata), $past(hold_ff[i])})
                else $error("high byte write did not load preload");

            AST_HIGH_READ_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && rd_hi[i] |=> rdata_ff == $past(count[i][15:8])
                && hold_ff[i] == $past(count[i][7:0]))
                else $error("high byte read not coherent");

            AST_READ_BLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && rd_hi[i] |=> $stable(count[i]))
                else $error("counter moved during read");

            AST_STOPPED_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && wr_hi[i] && !ctrl_ff[i][`DTEC_CTRL_RUN]
                |=> count[i] == {$past(wdata), $past(hold_ff[i])})
                else $error("stopped counter not loaded");

            AST_RUN_SOFT_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && ctrl_ff[i][`DTEC_CTRL_RUN] && !wr_ctl[i]
                && ctrl_ff[i][`DTEC_CTRL_MODE_HI:`DTEC_CTRL_MODE_LO] != 2'b11
                |=> ctrl_ff[i][`DTEC_CTRL_RUN])
                else $error("run cleared without software");

            AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && ovf[i] |=> flag_ff[i] && wake_ff)
                else $error("overflow lost its flag or wake");

            AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rst_b)
                clk_en && !irq_en[i] |=> !irq_ff[i])
                else $error("interrupt passed while disabled");

            AST_FREEZE: assert property (
                !clk_en
                |=> $stable(ctrl_ff[i]) && $stable(count[i]) && $stable(flag_ff[i]))
                else $error("state moved while frozen");

            AST_LOW_READ: assert property (
                clk_en && rd_en && dtec_hit(addr, OFF_LO)
                |=> rdata_ff == $past(hold_ff[i]))
                else $error("low read not from buffer");

            AST_FLAG_HOLD: assert property (
                clk_en && flag_ff[i] && !flag_clr[i]
                |=> flag_ff[i])
                else $error("flag dropped without clear");

            AST_STOPPED_HOLD: assert property (
                clk_en && !ctrl_ff[i][`DTEC_CTRL_RUN] && !wr_hi[i]
                |=> $stable(count[i]))
                else $error("stopped counter moved");

            AST_PRELOAD_KEEP: assert property (
                clk_en && !wr_hi[i]
                |=> $stable(preload[i]))
                else $error("preload moved without write");

            AST_PW_RUN_CLEAR: assert property (
                clk_en && run_clr[i] && !wr_ctl[i]
                |=> !ctrl_ff[i][`DTEC_CTRL_RUN])
                else $error("run not cleared after pulse");

            COV_OVF: cover property (@(posedge clk) disable iff (!rst_b) ovf[i]);
            COV_READ: cover property (@(posedge clk) disable iff (!rst_b) rd_hi[i] ##1 rd_en);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wake_ff <= 1'b0;
        end else if (clk_en) begin
            wake_ff <= |ovf;
        end
    end

    // read data live for one cycle only; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            if (!rd_en) begin
                rdata_ff <= 8'h00;
            end else if (dtec_hit(addr, `DTEC_OFF_C0_HIGH)) begin
                rdata_ff <= count[0][15:8];
            end else if (dtec_hit(addr, `DTEC_OFF_C0_LOW)) begin
                rdata_ff <= hold_ff[0];
            end else if (dtec_hit(addr, `DTEC_OFF_C0_CTRL)) begin
                rdata_ff <= ctrl_ff[0];
            end else if (dtec_hit(addr, `DTEC_OFF_C1_HIGH)) begin
                rdata_ff <= count[1][15:8];
            end else if (dtec_hit(addr, `DTEC_OFF_C1_LOW)) begin
                rdata_ff <= hold_ff[1];
            end else if (dtec_hit(addr, `DTEC_OFF_C1_CTRL)) begin
                rdata_ff <= ctrl_ff[1];
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    AST_C1_RESERVED: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && rd_en && dtec_hit(addr, `DTEC_OFF_C1_CTRL) |=> rdata_ff[2:0] == 3'h0 && !rdata_ff[5])
        else $error("reserved control bits not zero");

    AST_WAKE_CAUSE: assert property (
        clk_en && ovf == 2'h0
        |=> !wake_ff)
        else $error("wake without overflow");

    AST_RDATA_IDLE: assert property (
        clk_en && !rd_en
        |=> rdata_ff == 8'h00)
        else $error("read data stood too long");

    AST_C0_RESERVED: assert property (
        clk_en && rd_en && dtec_hit(addr, `DTEC_OFF_C0_CTRL)
        |=> !rdata_ff[5])
        else $error("reserved bit not zero");

    AST_C1_QUARTER: assert property (
        clk_en && tick[1]
        |=> !tick[1] && div4_ff == 2'h0)
        else $error("counter 1 tick not one in four");

    AST_PSC_SPACING: assert property (
        clk_en && tick[0] && !wr_ctl[0] && ctrl_ff[0][`DTEC_CTRL_PSC_HI:`DTEC_CTRL_PSC_LO] != 3'h0
        |=> !tick[0])
        else $error("prescaled tick came twice in a row");

    AST_IRQ_FOLLOW: assert property (
        clk_en && flag_ff[0] && irq_en[0]
        |=> irq_ff[0])
        else $error("enabled flag gave no interrupt");

    COV_WAKE: cover property (@(posedge clk) disable iff (!rst_b) wake_ff);

endmodule : dtec_top
`default_nettype wire

// ==== dtec_consts.svh ====
// Purpose: offsets, field positions and reset values of the dual counter block
// Assumes: byte wide register port with an 8-bit address
// Notes:   included by the top and channel design files of the block
`ifndef DTEC_CONSTS_SVH
`define DTEC_CONSTS_SVH

`define DTEC_OFF_C0_HIGH   8'h0C
`define DTEC_OFF_C0_LOW    8'h0D
`define DTEC_OFF_C0_CTRL   8'h0E
`define DTEC_OFF_C1_HIGH   8'h0F
`define DTEC_OFF_C1_LOW    8'h10
`define DTEC_OFF_C1_CTRL   8'h11

`define DTEC_CTRL_MODE_HI  7
`define DTEC_CTRL_MODE_LO  6
`define DTEC_CTRL_RUN      4
`define DTEC_CTRL_EDGE     3
`define DTEC_CTRL_PSC_HI   2
`define DTEC_CTRL_PSC_LO   0

`define DTEC_CTRL_RESET    8'h08
`define DTEC_CTR_MAX       16'hFFFF
`define DTEC_CTR1_DIV_LAST 2'h3
`define DTEC_PSC_WIDTH     7

`endif

// ==== dtec_pkg.sv ====
// Purpose: shared types of the dual counter block
// Assumes: nothing beyond the constants header
// Notes:   mode encoding is the control field bits 7:6
package dtec_pkg;

    typedef enum logic [1:0] {
        DTEC_MODE_UNUSED = 2'b00,
        DTEC_MODE_EVENT  = 2'b01,
        DTEC_MODE_TIMER  = 2'b10,
        DTEC_MODE_PULSE  = 2'b11
    } dtec_mode_e;

endpackage : dtec_pkg

// ==== dtec_channel.sv ====
// Purpose: one 16-bit up counter with preload, edge detect and pulse width logic
// Assumes: pin_sync already passed two flip-flops; tick is a one-cycle enable
// Notes:   run bit lives in the parent; this module asks for its clear
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.svh"

module dtec_channel (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    input  wire dtec_pkg::dtec_mode_e mode,
    input  wire logic              run,
    input  wire logic              edge_sel,
    input  wire logic              tick,
    input  wire logic              pin_sync,
    input  wire logic              load,
    input  wire logic [15:0]       load_val,
    input  wire logic              block,
    output logic                   run_clr,
    output var logic [15:0]        count_ff,
    output var logic [15:0]        preload_ff,
    output var logic               ovf_ff
);

    logic pin_prev_ff;
    logic pw_busy_ff;
    logic rise;
    logic fall;
    logic ev_edge;
    logic pw_start;
    logic pw_end;
    logic inc;

    assign rise     = pin_sync & ~pin_prev_ff;
    assign fall     = ~pin_sync & pin_prev_ff;
    assign ev_edge  = edge_sel ? fall : rise;
    assign pw_start = edge_sel ? rise : fall;
    assign pw_end   = edge_sel ? fall : rise;
    assign run_clr  = (mode == dtec_pkg::DTEC_MODE_PULSE) & pw_busy_ff & pw_end;

    always_comb begin
        inc = 1'b0;
        case (mode)
            dtec_pkg::DTEC_MODE_EVENT: inc = run & ev_edge;
            dtec_pkg::DTEC_MODE_TIMER: inc = run & tick;
            dtec_pkg::DTEC_MODE_PULSE: inc = run & pw_busy_ff & ~pw_end & tick;
            default:                   inc = 1'b0;
        endcase
        if (block) begin
            inc = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_prev_ff <= 1'b0;
        end else if (clk_en) begin
            pin_prev_ff <= pin_sync;
        end
    end

    // measurement window: armed only while run stays set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pw_busy_ff <= 1'b0;
        end else if (clk_en) begin
            if (mode != dtec_pkg::DTEC_MODE_PULSE || !run) begin
                pw_busy_ff <= 1'b0;
            end else if (!pw_busy_ff && pw_start) begin
                pw_busy_ff <= 1'b1;
            end else if (pw_busy_ff && pw_end) begin
                pw_busy_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            preload_ff <= 16'h0000;
        end else if (clk_en && load) begin
            preload_ff <= load_val;
        end
    end

    // a running counter keeps counting through a preload write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_ff <= 16'h0000;
            ovf_ff   <= 1'b0;
        end else if (clk_en) begin
            ovf_ff <= 1'b0;
            if (load && !run) begin
                count_ff <= load_val;
            end else if (inc) begin
                if (count_ff == `DTEC_CTR_MAX) begin
                    count_ff <= preload_ff;
                    ovf_ff   <= 1'b1;
                end else begin
                    count_ff <= count_ff + 16'h0001;
                end
            end
        end
    end

    AST_TIMER_STEP: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && mode == dtec_pkg::DTEC_MODE_TIMER && run && tick && !block && !load
        && count_ff != `DTEC_CTR_MAX |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("timer did not step by one");

    AST_OVF_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && inc && !load && count_ff == `DTEC_CTR_MAX
        |=> ovf_ff && count_ff == $past(preload_ff))
        else $error("overflow did not reload from preload");

    AST_PW_STOP: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && run_clr |=> !pw_busy_ff && $stable(count_ff))
        else $error("pulse measurement did not stop");

    COV_PW_DONE: cover property (@(posedge clk) disable iff (!rst_b) run_clr);

endmodule : dtec_channel
`default_nettype wire

// ==== dtec_pin_drive.sv ====
// Purpose: far-side source of one counter input pin
// Assumes: bursts of whole half periods, timed on the bench clock
// Notes:   the pin keeps its last level between bursts, as a real signal does
`timescale 1ns/1ps
`default_nettype none

module dtec_pin_drive (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [4:0] toggles,
    input  wire logic [7:0] half,
    output var logic        pin,
    output logic            busy
);
    logic [4:0] left_ff;
    logic [7:0] tmr_ff;

    initial begin
        pin = 1'b0;
        left_ff = 5'h0;
        tmr_ff = 8'h1;
    end

    // half periods of three or more clocks outlast the two-flop synchroniser
    always @(posedge clk) begin
        if (go) begin
            left_ff <= toggles;
            tmr_ff  <= half;
        end else if (left_ff != 5'h0 && tmr_ff == 8'h1) begin
            pin     <= ~pin;
            left_ff <= left_ff - 5'h1;
            tmr_ff  <= half;
        end else if (left_ff != 5'h0) begin
            tmr_ff <= tmr_ff - 8'h1;
        end
    end

    assign busy = (left_ff != 5'h0);

endmodule : dtec_pin_drive
`default_nettype wire

// ==== dtec_top_test.sv ====
// Purpose: self-checking bench of the dual counter block
// Assumes: reads are compared by a monitor one cycle after the strobe
// Notes:   timing checks use windows since prescaler phase is free-running
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.svh"

module dtec_top_test;
    typedef struct {
        logic [7:0] lo;
        logic [7:0] hi;
    } dtec_exp_s;

    logic       clk, cen, rst_b, wr_en, rd_en, rd_d, wake_up;
    logic [7:0] addr, wdata, rdata, half;
    logic [4:0] toggles;
    logic [1:0] pin, go, busy, ien, fclr, flag, irq;
    int         error_cnt, n_checks, wake_cnt;
    dtec_exp_s  exp_q[$];
    dtec_exp_s  e;

    dtec_top dtec_top_i (
        .clk(clk), .rst_b(rst_b), .clk_en(cen), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ctr0_input_pin(pin[0]), .ctr1_input_pin(pin[1]),
        .ctr0_irq_enable(ien[0]), .ctr1_irq_enable(ien[1]),
        .ctr0_flag_clr(fclr[0]), .ctr1_flag_clr(fclr[1]),
        .ctr0_overflow_flag(flag[0]), .ctr1_overflow_flag(flag[1]),
        .ctr0_irq(irq[0]), .ctr1_irq(irq[1]), .wake_up(wake_up)
    );
    dtec_pin_drive dtec_pin_drive_i0 (
        .clk(clk), .go(go[0]), .toggles(toggles), .half(half), .pin(pin[0]), .busy(busy[0])
    );
    dtec_pin_drive dtec_pin_drive_i1 (
        .clk(clk), .go(go[1]), .toggles(toggles), .half(half), .pin(pin[1]), .busy(busy[1])
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    // read results land one cycle after the strobe and only then
    always @(posedge clk) begin
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            chk(rdata >= e.lo && rdata <= e.hi, "read data");
        end
        rd_d <= rd_en;
        if (wake_up === 1'b1)
            wake_cnt++;
    end

    function automatic logic [7:0] reg_at(input int ch, input int k);
        return `DTEC_OFF_C0_HIGH + 8'(3 * ch + k);
    endfunction : reg_at

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        exp_q.push_back('{lo, hi});
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    task automatic load(input int ch, input logic [15:0] v);
        wr(reg_at(ch, 1), v[7:0]);
        wr(reg_at(ch, 0), v[15:8]);
    endtask : load

    task automatic clear_flag(input int ch);
        @(posedge clk);
        fclr[ch] <= 1'b1;
        @(posedge clk);
        fclr[ch] <= 1'b0;
        cyc(2);
    endtask : clear_flag

    task automatic wait_flag(input int ch, input int lo, input int hi);
        int n;
        n = 0;
        while (flag[ch] !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: no overflow", $time);
            tally_and_finish();
        end
        chk(n >= lo && n <= hi, "overflow time");
    endtask : wait_flag

    task automatic pulse_pin(input int ch, input logic [4:0] t, input logic [7:0] h);
        int n;
        n = 0;
        @(posedge clk);
        toggles  <= t;
        half     <= h;
        go[ch]   <= 1'b1;
        @(posedge clk);
        go[ch]   <= 1'b0;
        cyc(1);
        while (busy[ch] === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: pin burst hung", $time);
            tally_and_finish();
        end
        cyc(5);
    endtask : pulse_pin

    initial begin
        int         p, ch, k, t, ex, w;
        logic [7:0] lo, hi;
        logic [1:0] lvl;
        {cen, rst_b, wr_en, rd_en, rd_d} = 5'h10;
        {addr, wdata, toggles, half} = '0;
        {go, ien, fclr, lvl} = 8'h00;
        {error_cnt, n_checks, wake_cnt} = '0;
        void'($urandom(85138));
        cyc(8);
        rst_b <= 1'b1;
        cyc(1);
        rd(reg_at(0, 2), 8'h08, 8'h08);
        rd(reg_at(1, 2), 8'h08, 8'h08);
        rd(8'h00, 8'h00, 8'h00);
        wr(reg_at(0, 2), 8'h27);
        rd(reg_at(0, 2), 8'h07, 8'h07);
        wr(reg_at(1, 2), 8'h27);
        rd(reg_at(1, 2), 8'h00, 8'h00);
        $display("test done: control reset and unused bits");
        lo = 8'($urandom_range(255));
        hi = 8'($urandom_range(255));
        wr(reg_at(0, 1), lo);
        rd(reg_at(0, 0), 8'h00, 8'h00);
        rd(reg_at(0, 1), 8'h00, 8'h00);
        load(0, {hi, lo});
        rd(reg_at(0, 0), hi, hi);
        rd(reg_at(0, 1), lo, lo);
        $display("test done: byte buffer");
        for (p = 0; p < 8; p++) begin
            ien[0] <= p[0];
            wr(reg_at(0, 2), 8'h80 | 8'(p));
            load(0, 16'hFFFC);
            clear_flag(0);
            chk(flag[0] === 1'b0 && irq[0] === 1'b0, "flag clear");
            w = wake_cnt;
            wr(reg_at(0, 2), 8'h90 | 8'(p));
            wait_flag(0, 3 * (1 << p) + 1, 4 * (1 << p) + 4);
            cyc(1);
            chk(irq[0] === p[0], "irq gating");
            chk(wake_cnt > w, "wake pulse");
            wr(reg_at(0, 2), 8'h80 | 8'(p));
            rd(reg_at(0, 0), 8'hFF, 8'hFF);
        end
        $display("test done: prescaled timer overflow");
        ien[1] <= 1'b0;
        wr(reg_at(1, 2), 8'h80);
        load(1, 16'hFFF0);
        clear_flag(1);
        wr(reg_at(1, 2), 8'h90);
        load(1, 16'h1200);
        rd(reg_at(1, 0), 8'hFF, 8'hFF);
        wait_flag(1, 40, 70);
        cyc(1);
        chk(irq[1] === 1'b0, "masked irq");
        wr(reg_at(1, 2), 8'h80);
        rd(reg_at(1, 0), 8'h12, 8'h12);
        cen <= 1'b0;
        wr(reg_at(1, 2), 8'h90);
        cen <= 1'b1;
        rd(reg_at(1, 2), 8'h80, 8'h80);
        $display("test done: preload while running");
        for (ch = 0; ch < 2; ch++) begin
            for (k = 0; k < 2; k++) begin
                t = k ? 5 : 7;
                ex = (lvl[ch] ^ k[0]) ? t / 2 : (t + 1) / 2;
                wr(reg_at(ch, 2), 8'h40 | 8'(k << 3));
                load(ch, 16'h0000);
                wr(reg_at(ch, 2), 8'h50 | 8'(k << 3));
                pulse_pin(ch, 5'(t), ch ? 8'h06 : 8'h03);
                lvl[ch] = lvl[ch] ^ t[0];
                wr(reg_at(ch, 2), 8'h40 | 8'(k << 3));
                rd(reg_at(ch, 0), 8'h00, 8'h00);
                rd(reg_at(ch, 1), 8'(ex), 8'(ex));
            end
        end
        $display("test done: event counting on both edges");
        wr(reg_at(0, 2), 8'hC8);
        load(0, 16'h0000);
        wr(reg_at(0, 2), 8'hD8);
        for (k = 0; k < 2; k++) begin
            pulse_pin(0, 5'h2, 8'h28);
            rd(reg_at(0, 2), 8'hC8, 8'hC8);
            rd(reg_at(0, 0), 8'h00, 8'h00);
            rd(reg_at(0, 1), 8'h25, 8'h2B);
        end
        $display("test done: pulse width");
        cyc(3);
        tally_and_finish();
    end

endmodule : dtec_top_test
`default_nettype wire
